// >>> card_response_framer.sv
// Card-side response framer: builds response frames and shifts them out on the
// command line, and holds the data line busy after a busy-variant response.
// Assumes a host drives the card clock pin; software reaches the registers
// over Avalon-MM with waitrequest.
// Operation
// - Send response serially, MSB first, typed length
// - Start bit 0, direction 0, end bit 1
// - CRC7 in bits 7:1 except operating-conditions reply
// - Normal response 48 bits, index, status
// - Busy variant may hold data line busy
// - Identity and specific data use 136 bits
// - Long frame: ones at 133:128, register 127:1
// - Operating-conditions reply: index ones, CRC ones
// - Published address reply index is 000011
// - Upper argument half carries relative address
// - Lower half: status 23,22,19,12:0 packed
// - Interface reply index 001000, 39:22 zero
// - No interface reply unless voltage accepted
// - Echo voltage field and check pattern
// - Bit 21 reports third supply rail
// - Bit 20 reports serial alternative interface
// - Voltage code 0001b normal, 0010b low
// - After low-voltage identification report 0010b
// - Boot state left only by reset command
// - Conditions reply busy while initialising or capacity mismatch
// - Reserved card status bits read zero
`timescale 1ns/10ps
module card_response_framer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [card_response_framer_pkg::AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic link_clk_i,
  input wire logic cmd_i,
  output card_response_framer_pkg::card_pins_t pins_o
);
  import card_response_framer_pkg::*;

  logic link_fall;
  logic ack_r;
  logic [31:0] readdata_r;
  logic wr_en;
  logic [31:0] ctrl_r;
  logic [31:0] card_status_r;
  logic [31:0] op_cond_r;
  logic [15:0] rel_addr_r;
  logic [11:0] cmd8_arg_r;
  logic [7:0] config_r;
  logic [31:0] ident_r [0:3];
  logic [31:0] spec_r [0:3];
  logic boot_r;
  logic busy_hold_r;
  logic suppressed_r;
  logic refused_r;
  frame_state_t state_r;
  frame_state_t state_nxt;
  logic [FRAME_W-1:0] frame_r;
  logic [7:0] bits_left_r;
  logic cmd_r;
  logic cmd_oe_r;
  logic dat0_oe_r;
  logic go;
  logic accept_go;
  rsp_type_t go_type;
  logic [5:0] go_index;
  logic [31:0] status_clean;
  logic [31:0] short_arg;
  logic [39:0] short_head;
  logic [6:0] short_crc;
  logic [6:0] short_crc_field;
  logic [127:0] long_reg;
  logic [3:0] volt_field;
  logic volt_ok;
  logic op_cond_busy;
  logic [5:0] head_index;
  logic sends_frame;
  logic cmd_sync_meta_r;
  logic cmd_sync_r;

  link_clock_sampler u_sampler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .link_clk_i(link_clk_i),
    .fall_o(link_fall)
  );

  // Bus slave: one wait cycle, then the access completes
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign avs_readdata_o = readdata_r;
  assign wr_en = ce_i & avs_write_i & ack_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else if (ce_i) begin
      ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      readdata_r <= 32'h00000000;
    end else if (ce_i && avs_read_i && !ack_r) begin
      case (avs_address_i)
        REG_CTRL: readdata_r <= {ctrl_r[31:14], ctrl_r[13:0]} & 32'h40003f07;
        REG_STATUS: readdata_r <= {24'h000000, cmd_sync_r, refused_r, suppressed_r, busy_hold_r, boot_r, state_r};
        REG_CARD_STATUS: readdata_r <= card_status_r;
        REG_OP_COND: readdata_r <= op_cond_r;
        REG_REL_ADDR: readdata_r <= {16'h0000, rel_addr_r};
        REG_CMD8_ARG: readdata_r <= {20'h00000, cmd8_arg_r};
        REG_CONFIG: readdata_r <= {24'h000000, config_r & 8'h3f};
        default: begin
          if (avs_address_i >= REG_IDENT0 && avs_address_i < REG_SPEC0) begin
            readdata_r <= ident_r[2'(avs_address_i - REG_IDENT0)];
          end else if (avs_address_i >= REG_SPEC0 && avs_address_i <= REG_LAST) begin
            readdata_r <= spec_r[2'(avs_address_i - REG_SPEC0)];
          end else begin
            readdata_r <= 32'h00000000;
          end
        end
      endcase
    end
  end

  // Software-written contents
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= 32'h00000000;
      card_status_r <= 32'h00000000;
      op_cond_r <= 32'h00000000;
      rel_addr_r <= 16'h0000;
      cmd8_arg_r <= 12'h000;
      config_r <= CFG_RESET;
      for (int i = 0; i < 4; i++) begin
        ident_r[i] <= 32'h00000000;
        spec_r[i] <= 32'h00000000;
      end
    end else if (wr_en) begin
      case (avs_address_i)
        REG_CTRL: ctrl_r <= avs_writedata_i;
        REG_CARD_STATUS: card_status_r <= avs_writedata_i;
        REG_OP_COND: op_cond_r <= avs_writedata_i;
        REG_REL_ADDR: rel_addr_r <= avs_writedata_i[15:0];
        REG_CMD8_ARG: cmd8_arg_r <= avs_writedata_i[11:0];
        REG_CONFIG: config_r <= avs_writedata_i[7:0];
        default: begin
          if (avs_address_i >= REG_IDENT0 && avs_address_i < REG_SPEC0) begin
            ident_r[2'(avs_address_i - REG_IDENT0)] <= avs_writedata_i;
          end else if (avs_address_i >= REG_SPEC0 && avs_address_i <= REG_LAST) begin
            spec_r[2'(avs_address_i - REG_SPEC0)] <= avs_writedata_i;
          end
        end
      endcase
    end
  end

  // Command line is only observed, for software visibility
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_sync_meta_r <= 1'b1;
      cmd_sync_r <= 1'b1;
    end else if (ce_i) begin
      cmd_sync_meta_r <= cmd_i;
      cmd_sync_r <= cmd_sync_meta_r;
    end
  end

  // A write of CTRL with the go bit requests one response
  assign go = wr_en && avs_address_i == REG_CTRL && avs_writedata_i[CTRL_GO_BIT];
  assign go_type = rsp_type_t'(avs_writedata_i[CTRL_TYPE_LSB +: 3]);
  assign go_index = avs_writedata_i[CTRL_INDEX_LSB +: 6];
  // In boot state only the reset command is served
  assign accept_go = go && state_r == ST_IDLE && (!boot_r || go_index == IDX_RESET);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_r <= 1'b0;
    end else if (accept_go && go_index == IDX_RESET) begin
      boot_r <= 1'b0;
    end else if (wr_en && avs_address_i == REG_CONFIG && avs_writedata_i[CFG_BOOT_ENTER]) begin
      boot_r <= 1'b1;
    end
  end

  // A refused go starts no frame and only updates CTRL, so software polls this flag to learn of it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      refused_r <= 1'b0;
    end else if (go) begin
      refused_r <= ~accept_go;
    end
  end

  // Field assembly
  assign status_clean = card_status_r & STATUS_USED_MASK;
  // Low-voltage completion overrides the echoed code, so the host sees the switch took
  assign volt_field = config_r[CFG_LOW_VOLT_DONE] ? VOLT_LOW : cmd8_arg_r[11:8];
  assign volt_ok = config_r[CFG_LOW_VOLT_DONE] || cmd8_arg_r[11:8] == VOLT_27_36;
  assign op_cond_busy = ~config_r[CFG_INIT_DONE] | (config_r[CFG_HIGH_CAP] & ~config_r[CFG_CAP_FLAG]);
  assign sends_frame = go_type != RSP_NONE && (go_type != RSP_IF_COND || volt_ok);

  always_comb begin
    head_index = go_index;
    short_arg = status_clean;
    case (go_type)
      RSP_OP_COND: begin
        head_index = IDX_ALL_ONES;
        short_arg = {~op_cond_busy, op_cond_r[OP_COND_READY_BIT-1:0]};
      end
      RSP_PUBLISH: begin
        head_index = IDX_PUBLISH_ADDR;
        short_arg = {rel_addr_r, status_clean[23], status_clean[22], status_clean[19], status_clean[12:0]};
      end
      RSP_IF_COND: begin
        head_index = IDX_IF_COND;
        short_arg = {18'h00000, config_r[CFG_RAIL12], config_r[CFG_SERIAL_ALT], volt_field,
                     cmd8_arg_r[7:0]};
      end
      default: begin
        head_index = go_index;
        short_arg = status_clean;
      end
    endcase
  end

  assign short_head = {1'b0, 1'b0, head_index, short_arg};

  response_crc7 u_crc (
    .data_i(short_head),
    .crc_o(short_crc)
  );

  // The conditions reply carries no real check field, so it is forced to ones
  assign short_crc_field = go_type == RSP_OP_COND ? CRC_ALL_ONES : short_crc;
  // Only one long register is staged, chosen by the reply type
  assign long_reg = go_type == RSP_SPECIFIC ? {spec_r[3], spec_r[2], spec_r[1], spec_r[0]}
                                            : {ident_r[3], ident_r[2], ident_r[1], ident_r[0]};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      suppressed_r <= 1'b0;
    end else if (accept_go) begin
      suppressed_r <= go_type == RSP_IF_COND && !volt_ok;
    end
  end

  // Frame sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (accept_go && sends_frame) begin
          state_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (ce_i && link_fall && bits_left_r == 8'd0) begin
          state_nxt = busy_hold_r ? ST_BUSY : ST_IDLE;
        end
      end
      ST_BUSY: begin
        if (!busy_hold_r) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

  // Busy is held until software releases it; release wins only when no new busy is asked
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_hold_r <= 1'b0;
    end else if (accept_go && sends_frame) begin
      busy_hold_r <= go_type == RSP_NORMAL && avs_writedata_i[CTRL_BUSY_BIT];
    end else if (wr_en && avs_address_i == REG_CONFIG && avs_writedata_i[CFG_BUSY_RELEASE]) begin
      busy_hold_r <= 1'b0;
    end
  end

  // Shift register: bit FRAME_W-1 is always the next bit on the line
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_r <= '0;
      bits_left_r <= 8'd0;
    end else if (ce_i) begin
      if (accept_go && sends_frame) begin
        if (go_type == RSP_IDENTITY || go_type == RSP_SPECIFIC) begin
          frame_r <= {1'b0, 1'b0, IDX_ALL_ONES, long_reg[127:1], 1'b1};
          bits_left_r <= LEN_LONG;
        end else begin
          frame_r <= {short_head, short_crc_field, 1'b1, 88'h0};
          bits_left_r <= LEN_SHORT;
        end
      end else if (state_r == ST_SHIFT && link_fall && bits_left_r != 8'd0) begin
        frame_r <= {frame_r[FRAME_W-2:0], 1'b0};
        bits_left_r <= bits_left_r - 8'd1;
      end
    end
  end

  // Line drivers change on the card clock's falling edge so the host samples a settled bit
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_r <= 1'b1;
      cmd_oe_r <= 1'b0;
    end else if (ce_i && state_r == ST_SHIFT && link_fall) begin
      if (bits_left_r == 8'd0) begin
        cmd_r <= 1'b1;
        cmd_oe_r <= 1'b0;
      end else begin
        cmd_r <= frame_r[FRAME_W-1];
        cmd_oe_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dat0_oe_r <= 1'b0;
    end else if (ce_i) begin
      dat0_oe_r <= state_nxt == ST_BUSY;
    end
  end

  // One assignment in field order keeps a single driver on the carrier
  assign pins_o = {cmd_r, cmd_oe_r, 1'b0, dat0_oe_r};
endmodule : card_response_framer

// >>> card_response_framer_pkg.sv
// Constants, types and the register map of the card response framer.
// Assumes a 32-bit Avalon-MM slave port addressed by word index.
package card_response_framer_pkg;

  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned AW = 4;

  // Register word indices
  localparam logic [AW-1:0] REG_CTRL = 4'h0;
  localparam logic [AW-1:0] REG_STATUS = 4'h1;
  localparam logic [AW-1:0] REG_CARD_STATUS = 4'h2;
  localparam logic [AW-1:0] REG_OP_COND = 4'h3;
  localparam logic [AW-1:0] REG_REL_ADDR = 4'h4;
  localparam logic [AW-1:0] REG_CMD8_ARG = 4'h5;
  localparam logic [AW-1:0] REG_CONFIG = 4'h6;
  localparam logic [AW-1:0] REG_IDENT0 = 4'h7;
  localparam logic [AW-1:0] REG_SPEC0 = 4'hb;
  localparam logic [AW-1:0] REG_LAST = 4'he;

  // CTRL fields
  localparam int unsigned CTRL_TYPE_LSB = 0;
  localparam int unsigned CTRL_INDEX_LSB = 8;
  localparam int unsigned CTRL_BUSY_BIT = 30;
  localparam int unsigned CTRL_GO_BIT = 31;

  // CONFIG fields
  localparam int unsigned CFG_INIT_DONE = 0;
  localparam int unsigned CFG_HIGH_CAP = 1;
  localparam int unsigned CFG_CAP_FLAG = 2;
  localparam int unsigned CFG_RAIL12 = 3;
  localparam int unsigned CFG_SERIAL_ALT = 4;
  localparam int unsigned CFG_LOW_VOLT_DONE = 5;
  localparam int unsigned CFG_BOOT_ENTER = 6;
  localparam int unsigned CFG_BUSY_RELEASE = 7;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // Frame layout
  localparam int unsigned FRAME_W = 136;
  localparam logic [7:0] LEN_SHORT = 8'd48;
  localparam logic [7:0] LEN_LONG = 8'd136;
  localparam logic [5:0] IDX_ALL_ONES = 6'h3f;
  localparam logic [5:0] IDX_PUBLISH_ADDR = 6'h03;
  localparam logic [5:0] IDX_IF_COND = 6'h08;
  localparam logic [5:0] IDX_RESET = 6'h00;
  localparam logic [6:0] CRC_ALL_ONES = 7'h7f;
  localparam logic [6:0] CRC_POLY = 7'h09;
  localparam logic [3:0] VOLT_27_36 = 4'h1;
  localparam logic [3:0] VOLT_LOW = 4'h2;
  localparam logic [31:0] STATUS_USED_MASK = 32'hfff9ffff;
  localparam int unsigned OP_COND_READY_BIT = 31;

  typedef enum logic [2:0] {
    RSP_NONE = 3'h0,
    RSP_NORMAL = 3'h1,
    RSP_IDENTITY = 3'h2,
    RSP_SPECIFIC = 3'h3,
    RSP_OP_COND = 3'h4,
    RSP_PUBLISH = 3'h5,
    RSP_IF_COND = 3'h6
  } rsp_type_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_BUSY = 3'b100
  } frame_state_t;

  typedef struct packed {
    logic cmd;
    logic cmd_oe;
    logic dat0;
    logic dat0_oe;
  } card_pins_t;

endpackage : card_response_framer_pkg

// >>> card_response_framer_properties.sv
// Concurrent checks on the framer ports: the bus wait state and the frame shape.
// Assumes one clock domain and a link clock far slower than clk_i.
`timescale 1ns/10ps
module card_response_framer_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire card_response_framer_pkg::card_pins_t pins_o
);
  import card_response_framer_pkg::*;
  logic [11:0] oe_cnt_r;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Counts driven cycles, so that a frame length can be judged at its end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      oe_cnt_r <= 12'h000;
    end else if (pins_o.cmd_oe) begin
      oe_cnt_r <= oe_cnt_r + 12'h001;
    end else begin
      oe_cnt_r <= 12'h000;
    end
  end
  chk_one_wait_state: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i |=> !avs_waitrequest_o)
    else $error("bus request not answered after one wait state");
  chk_no_wait_idle: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("waitrequest high without a request");
  chk_start_dir_zero: assert property ($rose(pins_o.cmd_oe) |-> (!pins_o.cmd)[*8] ##1 (!pins_o.cmd)[*7])
    else $error("start or direction bit not zero");
  chk_idle_high: assert property (!pins_o.cmd_oe |-> pins_o.cmd)
    else $error("command line value not high while idle");
  chk_end_bit_one: assert property ($fell(pins_o.cmd_oe) |-> $past(pins_o.cmd))
    else $error("frame did not close with a one");
  chk_frame_length: assert property ($fell(pins_o.cmd_oe) |-> oe_cnt_r inside {[382:386], [1086:1090]})
    else $error("frame length is neither 48 nor 136 bits");
  chk_bit_period: assert property ($changed(pins_o.cmd) && pins_o.cmd_oe |=> $stable(pins_o.cmd)[*6])
    else $error("command bit shorter than a link period");
  chk_busy_level: assert property (pins_o.dat0_oe |-> !pins_o.dat0 && !pins_o.cmd_oe)
    else $error("busy held with a high level or during a frame");
  chk_busy_after_frame: assert property ($rose(pins_o.dat0_oe) |-> !pins_o.cmd_oe)
    else $error("busy raised during a frame");
endmodule : card_response_framer_properties

// >>> host_link_model.sv
// Host side of the link: makes the card clock within frames and captures
// the response bits. Assumes the bench pulls the lines up when released.
`timescale 1ns/10ps
module host_link_model (
  input wire logic run_i,
  input wire logic clr_i,
  input wire card_response_framer_pkg::card_pins_t pins_i,
  output logic link_clk_o,
  output logic [135:0] frame_o,
  output logic [7:0] count_o,
  output logic busy_o
);
  import card_response_framer_pkg::*;
  // Stands still low between frames; a running half period is finished first
  initial begin
    link_clk_o = 1'b0;
    forever begin
      #80;
      if (run_i || link_clk_o) link_clk_o = ~link_clk_o;
    end
  end
  // Sampled on the falling edge, before the card moves to its next bit
  always @(negedge link_clk_o or posedge clr_i) begin
    if (clr_i) begin
      frame_o <= '0;
      count_o <= 8'h00;
    end else if (pins_i.cmd_oe) begin
      frame_o <= {frame_o[134:0], pins_i.cmd};
      count_o <= count_o + 8'h01;
    end
  end
  assign busy_o = !(pins_i.dat0_oe ? pins_i.dat0 : 1'b1);
endmodule : host_link_model

// >>> link_clock_sampler.sv
// Two-flop synchroniser for the host's card clock, with falling-edge detect.
// Assumes the link clock is far slower than clk_i.
`timescale 1ns/10ps
module link_clock_sampler (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic link_clk_i,
  output logic fall_o
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else if (ce_i) begin
      meta_r <= link_clk_i;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign fall_o = ce_i & last_r & ~sync_r;
endmodule : link_clock_sampler

// >>> response_crc7.sv
// Combinational 7-bit CRC over the 40 leading bits of a short frame.
// Used only at frame load time, so the loop depth costs no link timing.
`timescale 1ns/10ps
module response_crc7 (
  input wire logic [39:0] data_i,
  output logic [6:0] crc_o
);
  import card_response_framer_pkg::*;

  always_comb begin
    logic [6:0] rem;
    logic fb;
    rem = 7'h00;
    fb = 1'b0;
    for (int i = 39; i >= 0; i--) begin
      fb = rem[6] ^ data_i[i];
      rem = {rem[5:0], 1'b0};
      if (fb) begin
        rem = rem ^ CRC_POLY;
      end
    end
    crc_o = rem;
  end
endmodule : response_crc7

// >>> tb_card_response_framer.sv
// Testbench: drives the register bus, runs the host link model and compares
// every frame with frames built here. Assumes the one-wait-state bus.
`timescale 1ns/10ps
module tb_card_response_framer;
  import card_response_framer_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [AW-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic link_clk;
  logic cmd_w;
  card_pins_t pins;
  logic run = 1'b0;
  logic clr = 1'b0;
  logic [135:0] cap;
  logic [7:0] cnt;
  logic busy;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'd60;
  logic [31:0] q, st, opc, raddr, cfg;
  logic [127:0] reg128;
  logic [5:0] idx;
  logic [7:0] pat;
  logic [3:0] vf;
  always #10 clk_i = ~clk_i;
  // Pull-up on the command line when the card releases it
  assign cmd_w = pins.cmd_oe ? pins.cmd : 1'b1;
  card_response_framer dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .link_clk_i(link_clk),
    .cmd_i(cmd_w), .pins_o(pins));
  host_link_model host (.run_i(run), .clr_i(clr), .pins_i(pins), .link_clk_o(link_clk), .frame_o(cap),
    .count_o(cnt), .busy_o(busy));
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function logic [135:0] sf(input logic [5:0] i, input logic [31:0] a, input logic opc_rsp);
    logic [39:0] h;
    logic [6:0] c;
    h = {2'b00, i, a};
    c = 7'h00;
    for (int k = 39; k >= 0; k--) begin
      c = {c[5:0], 1'b0} ^ ((h[k] ^ c[6]) ? 7'h09 : 7'h00);
    end
    if (opc_rsp) c = 7'h7f;
    return {88'h0, h, c, 1'b1};
  endfunction : sf
  task automatic check(input string nm, input logic [135:0] e, input logic [135:0] s);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus
  task automatic frame(input logic [31:0] ctl, input logic [7:0] len, input logic [135:0] e);
    @(posedge clk_i);
    clr <= 1'b1;
    run <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    bus(1'b1, REG_CTRL, ctl | 32'h80000000);
    for (int k = 0; k < 1600; k++) begin
      @(posedge clk_i);
      if (len != 0 && cnt === len && pins.cmd_oe === 1'b0) break;
    end
    run <= 1'b0;
    check("frame length", {128'h0, len}, {128'h0, cnt});
    if (len != 0) check("frame bits", e, cap);
  endtask : frame
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #1500000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, REG_STATUS, 32'h0);
    check("status after reset", 136'(32'h81), 136'(q));
    bus(1'b1, 4'hf, xs());
    bus(1'b0, 4'hf, 32'h0);
    check("unmapped read", 136'(0), 136'(q));
    st = xs();
    opc = xs();
    raddr = xs();
    bus(1'b1, REG_CARD_STATUS, st);
    bus(1'b1, REG_OP_COND, opc);
    bus(1'b1, REG_REL_ADDR, raddr);
    repeat (3) begin
      idx = 6'(xs());
      frame({18'h0, idx, 8'h01}, 48, sf(idx, st & 32'hfff9ffff, 1'b0));
    end
    for (int i = 0; i < 4; i++) begin
      cfg = (i == 0) ? 32'h0 : (i == 1) ? 32'h3 : (i == 2) ? 32'h1 : 32'h7;
      bus(1'b1, REG_CONFIG, cfg);
      frame(32'h4, 48, sf(6'h3f, {i[1], opc[30:0]}, 1'b1));
    end
    frame(32'h2a05, 48, sf(6'h03, {raddr[15:0], st[23], st[22], st[19], st[12:0]}, 1'b0));
    for (int t = 2; t < 4; t++) begin
      reg128 = {xs(), xs(), xs(), xs()};
      for (int w = 0; w < 4; w++) bus(1'b1, (t == 2 ? REG_IDENT0 : REG_SPEC0) + 4'(w), reg128[w*32 +: 32]);
      frame(32'(t), 136, {2'b00, 6'h3f, reg128[127:1], 1'b1});
    end
    for (int i = 0; i < 3; i++) begin
      cfg = (i == 0) ? 32'h8 : (i == 1) ? 32'h10 : 32'h30;
      pat = 8'(xs());
      vf = (i == 2) ? 4'h2 : 4'h1;
      bus(1'b1, REG_CONFIG, cfg);
      bus(1'b1, REG_CMD8_ARG, {20'h0, (i == 1) ? 4'h2 : 4'h1, pat});
      frame(32'h6, (i == 1) ? 8'd0 : 8'd48, sf(6'h08, {18'h0, cfg[3], cfg[4], vf, pat}, 1'b0));
      bus(1'b0, REG_STATUS, 32'h0);
      check("reply suppressed", 136'(i == 1), 136'(q[5]));
    end
    frame(32'h40000701, 48, sf(6'h07, st & 32'hfff9ffff, 1'b0));
    repeat (2) @(posedge clk_i);
    check("data line busy", 136'(1), 136'(busy));
    bus(1'b1, REG_CTRL, 32'h80000001);
    bus(1'b0, REG_STATUS, 32'h0);
    check("go while busy", 136'(5'h1c), 136'({q[6], q[4], q[2:0]}));
    bus(1'b1, REG_CONFIG, cfg | 32'h80);
    repeat (2) @(posedge clk_i);
    check("data line released", 136'(0), 136'(busy));
    bus(1'b1, REG_CONFIG, 32'h40);
    bus(1'b0, REG_STATUS, 32'h0);
    check("boot entered", 136'(1), 136'(q[3]));
    frame(32'h0501, 0, 136'h0);
    bus(1'b0, REG_STATUS, 32'h0);
    check("boot refusal", 136'(3), 136'({q[6], q[3]}));
    frame(32'h0, 0, 136'h0);
    bus(1'b0, REG_STATUS, 32'h0);
    check("boot left", 136'(0), 136'(q[3]));
    frame(32'h0501, 48, sf(6'h05, st & 32'hfff9ffff, 1'b0));
    report_and_stop();
  end
endmodule : tb_card_response_framer
bind card_response_framer card_response_framer_properties chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .pins_o(pins_o));
